/* File: rtl/bsp_pkg.sv */
// Constants and types for the burst SRAM port logic
// What this block does
// - Write beats: first two in cycle t+1, last two in cycle t+2.
// - Read: first word 2.5 cycles after start, last word in cycle t+4.
// - Burst words go to start address, then the next three addresses.
// - Write data is sampled on rises of both input clocks.
// - Read data is launched on rises of both input clocks.
// - After reset, ports idle and read outputs undriven until a read.
// - A repeated read or write on the next rise is ignored.
// - A select is don't-care on the rise after it started an operation.
// - Both masks low: all 18 bits of the beat are written.
// - Only low mask asserted: bits 8..0 written, 17..9 kept.
// - Only high mask asserted: bits 17..9 written, 8..0 kept.
// - Both masks high: nothing written for that beat.
// - Masks are sampled per beat and may change inside a burst.
// - Read starts on select low at clock rise, address stored then.
// - Both selects low: read wins unless previous start was a read.
// - Read right after write to same place returns the new data.
// - Deselected read port finishes, then tristates after next inverted rise.
package bsp_pkg;

  localparam int DATA_W = 18;
  localparam int MASK_W = 2;
  localparam int SYNC_STAGES = 3;
  // Low lane is bits 8..0, high lane 17..9
  localparam int LOW_TOP = 8;
  localparam int HIGH_BOT = 9;
  localparam logic [1:0] MASK_NONE = 2'h3;
  // Read edge counter: beats go out on edges 5..8 after start, at counts 4..7
  localparam logic [2:0] RD_FIRST_EDGE = 3'h4;
  localparam logic [2:0] RD_LAST_EDGE = 3'h7;
  localparam logic [2:0] RD_EDGE_START = 3'h0;
  // Write beat phases
  localparam logic [1:0] WR_PH_BEAT1 = 2'h1;
  localparam logic [1:0] WR_PH_BEAT2 = 2'h2;
  localparam logic [1:0] WR_PH_BEAT3 = 2'h3;
  localparam logic [1:0] BEAT0 = 2'h0;
  localparam logic [1:0] BEAT1 = 2'h1;
  localparam logic [1:0] BEAT2 = 2'h2;
  localparam logic [1:0] BEAT3 = 2'h3;
  localparam logic [17:0] Q_RESET = 18'h00000;

  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} bsp_op_t;

endpackage

/* File: rtl/bsp_core.sv */
// Four-word burst SRAM port logic with masked writes and read bursts
`timescale 1ns/1ps
module bsp_core #(
  parameter int ADDR_W = 22
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic read_port_select_n_i,
  input wire logic write_port_select_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [bsp_pkg::DATA_W-1:0] data_i,
  input wire logic [bsp_pkg::MASK_W-1:0] byte_write_mask_n_i,
  output logic [bsp_pkg::DATA_W-1:0] q_o,
  output logic q_oe_n_o
);

  localparam int IN_W = 4 + bsp_pkg::MASK_W + ADDR_W + bsp_pkg::DATA_W;
  localparam int DEPTH = 1 << ADDR_W;

  // Merge one beat into a stored word under the active-low lane masks
  function automatic logic [17:0] merge_beat(
    input logic [17:0] old_w,
    input logic [17:0] new_w,
    input logic [1:0] mask_n
  );
    logic [17:0] res;
    res = old_w;
    if (!mask_n[0])
    begin
      res[bsp_pkg::LOW_TOP:0] = new_w[bsp_pkg::LOW_TOP:0];
    end
    if (!mask_n[1])
    begin
      res[17:bsp_pkg::HIGH_BOT] = new_w[17:bsp_pkg::HIGH_BOT];
    end
    return res;
  endfunction

  logic [IN_W-1:0] in_w;
  logic [IN_W-1:0] s1_r;
  logic [IN_W-1:0] s2_r;
  logic [IN_W-1:0] s3_r;
  logic k_lvl_r;
  logic kn_lvl_r;
  logic k_rise;
  logic kn_rise;
  logic any_edge;
  logic rps_n;
  logic wps_n;
  logic [ADDR_W-1:0] addr_s;
  logic [17:0] data_s;
  logic [1:0] mask_s;
  bsp_pkg::bsp_op_t prev_op_r;
  logic rd_start;
  logic wr_start;
  logic [ADDR_W-1:0] wpend_addr_r;
  logic wpend_r;
  logic [ADDR_W-1:0] waddr_r;
  logic wact_r;
  logic [1:0] wphase_r;
  logic mem_we;
  logic [ADDR_W-1:0] mem_widx;
  logic [1:0] rd_slot_r;
  logic [ADDR_W-1:0] raddr_r [2];
  logic [2:0] rcnt_r [2];
  logic rdrv;
  logic [ADDR_W-1:0] ridx;
  logic rd_seen_r;
  logic [17:0] mem [DEPTH];

  assign in_w = {k_i, k_n_i, read_port_select_n_i, write_port_select_n_i,
                 byte_write_mask_n_i, addr_i, data_i};

  // Three-stage capture of all pins; data taken from the last stage
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= in_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rps_n = s3_r[IN_W-3];
  assign wps_n = s3_r[IN_W-4];
  assign mask_s = s3_r[IN_W-5:IN_W-6];
  assign addr_s = s3_r[ADDR_W+17:18];
  assign data_s = s3_r[17:0];

  // A clock level counts once stages two and three agree
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      k_lvl_r <= 1'b0;
      kn_lvl_r <= 1'b0;
    end
    else
    begin
      if (s2_r[IN_W-1] == s3_r[IN_W-1])
      begin
        k_lvl_r <= s3_r[IN_W-1];
      end
      if (s2_r[IN_W-2] == s3_r[IN_W-2])
      begin
        kn_lvl_r <= s3_r[IN_W-2];
      end
    end
  end

  assign k_rise = s2_r[IN_W-1] & s3_r[IN_W-1] & ~k_lvl_r;
  assign kn_rise = s2_r[IN_W-2] & s3_r[IN_W-2] & ~kn_lvl_r;
  assign any_edge = k_rise | kn_rise;

  // Start decode; a port that just started is not looked at
  always_comb
  begin
    rd_start = 1'b0;
    wr_start = 1'b0;
    if (k_rise)
    begin
      if (!rps_n && prev_op_r != bsp_pkg::OP_READ)
      begin
        rd_start = 1'b1;
      end
      else if (!wps_n && prev_op_r != bsp_pkg::OP_WRITE)
      begin
        wr_start = 1'b1;
      end
    end
  end

  // History of the last start, refreshed at every positive rise
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prev_op_r <= bsp_pkg::OP_IDLE;
    end
    else if (k_rise)
    begin
      if (rd_start)
      begin
        prev_op_r <= bsp_pkg::OP_READ;
      end
      else if (wr_start)
      begin
        prev_op_r <= bsp_pkg::OP_WRITE;
      end
      else
      begin
        prev_op_r <= bsp_pkg::OP_IDLE;
      end
    end
  end

  // Pending write address; a new start may arrive mid-burst
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wpend_r <= 1'b0;
      wpend_addr_r <= '0;
    end
    else if (wr_start)
    begin
      wpend_r <= 1'b1;
      wpend_addr_r <= addr_s;
    end
    else if (k_rise && !wact_r)
    begin
      wpend_r <= 1'b0;
    end
  end

  // Write beat sequencer: K, inverted K, K, inverted K
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wact_r <= 1'b0;
      wphase_r <= bsp_pkg::BEAT0;
      waddr_r <= '0;
    end
    else if (k_rise)
    begin
      if (wact_r && wphase_r == bsp_pkg::WR_PH_BEAT2)
      begin
        wphase_r <= bsp_pkg::WR_PH_BEAT3;
      end
      else if (!wact_r && wpend_r)
      begin
        wact_r <= 1'b1;
        waddr_r <= wpend_addr_r;
        wphase_r <= bsp_pkg::WR_PH_BEAT1;
      end
    end
    else if (kn_rise && wact_r)
    begin
      if (wphase_r == bsp_pkg::WR_PH_BEAT1)
      begin
        wphase_r <= bsp_pkg::WR_PH_BEAT2;
      end
      else if (wphase_r == bsp_pkg::WR_PH_BEAT3)
      begin
        wact_r <= 1'b0;
      end
    end
  end

  // Array write for the current beat; masks taken fresh each beat
  always_comb
  begin
    mem_we = 1'b0;
    mem_widx = waddr_r;
    if (k_rise && !wact_r && wpend_r)
    begin
      mem_we = 1'b1;
      mem_widx = wpend_addr_r;
    end
    else if (k_rise && wact_r && wphase_r == bsp_pkg::WR_PH_BEAT2)
    begin
      mem_we = 1'b1;
      mem_widx = waddr_r + ADDR_W'(bsp_pkg::BEAT2);
    end
    else if (kn_rise && wact_r)
    begin
      mem_we = 1'b1;
      if (wphase_r == bsp_pkg::WR_PH_BEAT1)
      begin
        mem_widx = waddr_r + ADDR_W'(bsp_pkg::BEAT1);
      end
      else
      begin
        mem_widx = waddr_r + ADDR_W'(bsp_pkg::BEAT3);
      end
    end
    if (mask_s == bsp_pkg::MASK_NONE)
    begin
      mem_we = 1'b0;
    end
  end

  // Storage; writes retire before any later read beat, so reads see new data
  always_ff @(posedge clock_i)
  begin
    if (mem_we)
    begin
      mem[mem_widx] <= merge_beat(mem[mem_widx], data_s, mask_s);
    end
  end

  // Two read slots, since a burst outlives the start spacing
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rd_slot_r <= 2'h0;
      raddr_r[0] <= '0;
      raddr_r[1] <= '0;
      rcnt_r[0] <= bsp_pkg::RD_EDGE_START;
      rcnt_r[1] <= bsp_pkg::RD_EDGE_START;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (any_edge && rd_slot_r[i])
        begin
          rcnt_r[i] <= rcnt_r[i] + 3'h1;
          if (rcnt_r[i] == bsp_pkg::RD_LAST_EDGE)
          begin
            rd_slot_r[i] <= 1'b0;
          end
        end
      end
      if (rd_start)
      begin
        // Free slot: idle or retiring its last beat at this very edge
        if (!rd_slot_r[0] || (any_edge && rcnt_r[0] == bsp_pkg::RD_LAST_EDGE))
        begin
          rd_slot_r[0] <= 1'b1;
          raddr_r[0] <= addr_s;
          rcnt_r[0] <= bsp_pkg::RD_EDGE_START;
        end
        else
        begin
          rd_slot_r[1] <= 1'b1;
          raddr_r[1] <= addr_s;
          rcnt_r[1] <= bsp_pkg::RD_EDGE_START;
        end
      end
    end
  end

  // Pick the slot whose beat is due at this edge
  always_comb
  begin
    rdrv = 1'b0;
    ridx = raddr_r[0];
    for (int i = 0; i < 2; i++)
    begin
      if (any_edge && rd_slot_r[i] && rcnt_r[i] >= bsp_pkg::RD_FIRST_EDGE)
      begin
        rdrv = 1'b1;
        ridx = raddr_r[i] + ADDR_W'(rcnt_r[i] - bsp_pkg::RD_FIRST_EDGE);
      end
    end
  end

  // Output word and enable; release only on an inverted-clock rise
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q_o <= bsp_pkg::Q_RESET;
      q_oe_n_o <= 1'b1;
    end
    else if (rdrv)
    begin
      q_o <= mem[ridx];
      q_oe_n_o <= 1'b0;
    end
    else if (kn_rise)
    begin
      q_oe_n_o <= 1'b1;
    end
  end

  // Helper: has any read been started since reset
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rd_seen_r <= 1'b0;
    end
    else if (rd_start)
    begin
      rd_seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence read_just_started;
    k_rise && rd_start;
  endsequence

  sequence write_just_started;
    k_rise && wr_start;
  endsequence

  rd_repeat_ignored_a: assert property (
    k_rise && prev_op_r == bsp_pkg::OP_READ |-> !rd_start)
    else $error("read started twice in a row");

  wr_select_dontcare_a: assert property (
    k_rise && prev_op_r == bsp_pkg::OP_WRITE |-> !wr_start)
    else $error("write select not ignored after start");

  arb_read_wins_a: assert property (
    k_rise && !rps_n && !wps_n && prev_op_r != bsp_pkg::OP_READ |-> rd_start && !wr_start)
    else $error("read lost arbitration wrongly");

  arb_write_wins_a: assert property (
    k_rise && !wps_n && prev_op_r == bsp_pkg::OP_READ |-> wr_start)
    else $error("write lost arbitration after read");

  history_kept_a: assert property (
    read_just_started |=> prev_op_r == bsp_pkg::OP_READ)
    else $error("history missed a read start");

  wr_pending_a: assert property (
    write_just_started |=> wpend_r && wpend_addr_r == $past(addr_s))
    else $error("write address not held");

  wr_beat_pair_a: assert property (
    kn_rise && wact_r && wphase_r == bsp_pkg::WR_PH_BEAT1 |-> mem_we || mask_s == bsp_pkg::MASK_NONE
      ##1 wphase_r == bsp_pkg::WR_PH_BEAT2)
    else $error("second beat not taken on inverted rise");

  no_write_masked_a: assert property (
    mem_we |-> mask_s != bsp_pkg::MASK_NONE)
    else $error("fully masked beat was written");

  rd_first_beat_a: assert property (
    any_edge && rd_slot_r[0] && rcnt_r[0] == bsp_pkg::RD_FIRST_EDGE |=> !q_oe_n_o)
    else $error("first read word not driven on time");

  hiz_until_read_a: assert property (
    !rd_seen_r |-> q_oe_n_o)
    else $error("outputs driven before any read");

  tristate_release_a: assert property (
    kn_rise && !rdrv |=> q_oe_n_o)
    else $error("outputs not released after burst");

endmodule

/* File: tb/bsp_ctl_model.sv */
// Controller model driving the burst SRAM port pins
`timescale 1ns/1ps
module bsp_ctl_model #(
  parameter int ADDR_W = 6
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [17:0] q_i,
  input wire logic q_oe_n_i,
  output logic k_o,
  output logic k_n_o,
  output logic read_port_select_n_o,
  output logic write_port_select_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [17:0] data_o,
  output logic [1:0] byte_write_mask_n_o
);
  logic [3:0] ph;

  // Twelve-cycle input clock, parked low in reset
  always @(posedge clock_i or negedge resetn_i)
  begin
    // Both-high park is only a recommendation; K low avoids a false rise
    if (!resetn_i)
      ph <= 4'h6;
    else
      ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
  end
  assign k_o = (ph < 4'h6);
  assign k_n_o = !k_o;

  // Quiet pins until a burst is asked for
  initial
  begin
    read_port_select_n_o = 1'b1;
    write_port_select_n_o = 1'b1;
    addr_o = '0;
    data_o = 18'h00000;
    byte_write_mask_n_o = 2'h3;
  end

  // Pins change mid half-period, well clear of both clock rises
  task automatic at_ph(input logic [3:0] p);
    do
    begin
      @(posedge clock_i);
      #1;
    end while (ph != p);
  endtask

  // Write burst; hold time over, stale lines are inverted
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0][17:0] d,
                    input logic [3:0][1:0] m);
    at_ph(4'h9);
    write_port_select_n_o = 1'b0;
    addr_o = a;
    at_ph(4'h3);
    write_port_select_n_o = 1'b1;
    addr_o = ~a;
    for (int i = 0; i < 4; i++)
    begin
      at_ph(i[0] ? 4'h3 : 4'h9);
      data_o = d[i];
      byte_write_mask_n_o = m[i];
    end
    at_ph(4'h9);
    data_o = ~data_o;
    byte_write_mask_n_o = 2'h3;
  endtask

  // Read burst; hold repeats the select on the next rise
  task automatic rd(input logic [ADDR_W-1:0] a, input bit hold,
                    output logic [3:0][17:0] w, output logic [1:0] oe);
    at_ph(4'h9);
    read_port_select_n_o = 1'b0;
    addr_o = a;
    at_ph(4'h3);
    addr_o = ~a;
    if (hold)
      at_ph(4'h3);
    read_port_select_n_o = 1'b1;
    repeat (3 - hold) at_ph(4'h1);
    oe[1] = q_oe_n_i;
    for (int i = 0; i < 4; i++)
    begin
      w[i] = q_i;
      at_ph(i[0] ? 4'h1 : 4'h7);
    end
    oe[0] = q_oe_n_i;
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the burst SRAM port logic
`timescale 1ns/1ps
module tb_top;
  localparam int AW = 6;
  typedef struct {
    logic [AW-1:0] a;
    logic [3:0][17:0] d;
    logic [3:0][1:0] m;
  } bsp_row_t;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic k, k_n, read_port_select_n, write_port_select_n, q_oe_n;
  logic [AW-1:0] addr;
  logic [17:0] data, q;
  logic [1:0] byte_write_mask_n;
  logic [17:0] mem [64];
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // Second row: masks 00, low only, high only, none
  bsp_row_t rows [3] = '{
    '{6'h10, {18'h00F0F, 18'h15555, 18'h2AAAA, 18'h3FFFF}, {4{2'h0}}},
    '{6'h10, {18'h12345, 18'h0FF00, 18'h33CC3, 18'h01E1E}, {2'h3, 2'h1, 2'h2, 2'h0}},
    '{6'h3E, {18'h00004, 18'h00003, 18'h00002, 18'h00001}, {4{2'h0}}}
  };

  bsp_core #(.ADDR_W(AW)) i_bsp_core (.clock_i(clock_i), .resetn_i(resetn_i),
    .k_i(k), .k_n_i(k_n), .read_port_select_n_i(read_port_select_n),
    .write_port_select_n_i(write_port_select_n), .addr_i(addr), .data_i(data),
    .byte_write_mask_n_i(byte_write_mask_n), .q_o(q), .q_oe_n_o(q_oe_n));

  bsp_ctl_model #(.ADDR_W(AW)) i_bsp_ctl_model (.clock_i(clock_i),
    .resetn_i(resetn_i), .q_i(q), .q_oe_n_i(q_oe_n), .k_o(k), .k_n_o(k_n),
    .read_port_select_n_o(read_port_select_n),
    .write_port_select_n_o(write_port_select_n), .addr_o(addr), .data_o(data),
    .byte_write_mask_n_o(byte_write_mask_n));

  // Free-running 40 MHz clock
  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Reference array update, lane by lane, address wrapping
  task automatic ref_wr(input bsp_row_t r);
    for (int i = 0; i < 4; i++)
    begin
      if (!r.m[i][0])
        mem[AW'(r.a + i)][8:0] = r.d[i][8:0];
      if (!r.m[i][1])
        mem[AW'(r.a + i)][17:9] = r.d[i][17:9];
    end
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input bit hold);
    logic [3:0][17:0] w;
    logic [1:0] oe;
    i_bsp_ctl_model.rd(a, hold, w, oe);
    for (int i = 0; i < 4; i++)
      check(w[i], mem[AW'(a + i)]);
    check({16'h0000, oe}, 18'h00001);
  endtask

  task automatic idle_chk;
    check(q, 18'h00000);
    check({17'h00000, q_oe_n}, 18'h00001);
  endtask

  // Hang guard, a few thousand cycles above the expected run
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      $display("Error at %0t: run timed out", $time);
      print_verdict();
    end
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    idle_chk();
    for (int r = 0; r < 3; r++)
    begin
      i_bsp_ctl_model.wr(rows[r].a, rows[r].d, rows[r].m);
      ref_wr(rows[r]);
      rd_chk(rows[r].a, 1'b0);
      $display("Row %0d done", r);
    end
    // Read of a location written one rise earlier
    rows[0].a = 6'h20;
    ref_wr(rows[0]);
    fork
      i_bsp_ctl_model.wr(rows[0].a, rows[0].d, rows[0].m);
      begin
        i_bsp_ctl_model.at_ph(4'h9);
        rd_chk(6'h20, 1'b0);
      end
    join
    $display("Forwarding test done");
    // Select held over two rises: second request ignored
    rd_chk(6'h10, 1'b1);
    $display("Repeat select test done");
    // Both selects from idle: read wins, write dropped
    fork
      i_bsp_ctl_model.wr(6'h3E, rows[1].d, {4{2'h0}});
      rd_chk(6'h3E, 1'b0);
    join
    rd_chk(6'h3E, 1'b0);
    $display("Arbitration test done");
    // Reset in mid-run returns outputs to idle
    resetn_i = 1'b0;
    repeat (10) @(posedge clock_i);
    idle_chk();
    #1 resetn_i = 1'b1;
    idle_chk();
    rd_chk(6'h10, 1'b0);
    $display("Reset test done");
    print_verdict();
  end
endmodule
